// ==== src/sbde_pkg.sv ====
// Constants, register map and carrier types for the instruction executor.
// Assumes one core clock; phases Q1..Q4 take one clock each.
package sbde_pkg;
   // Register byte offsets
   localparam logic [7:0] SBDE_OFF_CTRL = 8'h00;
   localparam logic [7:0] SBDE_OFF_INSTR = 8'h04;
   localparam logic [7:0] SBDE_OFF_ACC = 8'h08;
   localparam logic [7:0] SBDE_OFF_STATUS = 8'h0c;
   localparam logic [7:0] SBDE_OFF_BANK = 8'h10;
   localparam logic [7:0] SBDE_OFF_INDEX = 8'h14;
   localparam logic [7:0] SBDE_OFF_MADDR = 8'h18;
   localparam logic [7:0] SBDE_OFF_MDATA = 8'h1c;
   // Field positions in the instruction register
   localparam int SBDE_INS_TWO_BIT = 16;
   localparam int SBDE_INS_BUSY_BIT = 17;
   localparam int SBDE_INS_SKIP_BIT = 18;
   // Values after reset
   localparam logic [7:0] SBDE_RST_ACC = 8'h00;
   localparam logic [3:0] SBDE_RST_BANK = 4'h0;
   localparam logic [11:0] SBDE_RST_INDEX = 12'h000;
   // Opcodes
   localparam logic [15:0] SBDE_OPC_DECIMAL_ADJUST = 16'h0007;
   localparam logic [5:0] SBDE_OPC_DECREMENT_FILE = 6'h01;
   localparam logic [6:0] SBDE_OPC_COMPARE_SKIP_LESS = 7'h30;
   // Addressing limits
   localparam logic [7:0] SBDE_ILO_MAX = 8'h5f;
   localparam logic [3:0] SBDE_ACCESS_HIGH_BANK = 4'hf;
   // Decimal adjust constants
   localparam logic [3:0] SBDE_BCD_MAX = 4'h9;
   localparam logic [3:0] SBDE_BCD_FIX = 4'h6;
   // Memory geometry
   localparam int SBDE_MEM_AW = 12;
   localparam int SBDE_MEM_DEPTH = 4096;

   typedef struct packed
   {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } sbde_flags_t;

   typedef struct packed
   {
      logic [7:0] addr;
      logic write;
      logic valid;
   } sbde_aphase_t;

   typedef enum logic [1:0] {SBDE_Q1 = 2'b00, SBDE_Q2 = 2'b01,
                             SBDE_Q3 = 2'b11, SBDE_Q4 = 2'b10} sbde_phase_t;

   typedef enum logic [1:0] {SBDE_IDLE = 2'b00, SBDE_RUN = 2'b01,
                             SBDE_SKIP = 2'b11} sbde_state_t;
endpackage : sbde_pkg

// ==== src/sbde_core.sv ====
// Executor for compare-skip-less, decimal adjust and decrement-file.
// Assumes an AHB-Lite master on the same clock and a single slave.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sbde_core
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic o_busy,
   output logic o_skip_phase
);
   import sbde_pkg::*;

   logic [1:0] rst_sync_reg;
   logic rst_n;
   sbde_aphase_t ap_reg;
   logic ctrl_ext_reg;
   logic [15:0] instr_reg;
   logic two_word_reg;
   logic last_skip_reg;
   logic [7:0] acc_reg;
   sbde_flags_t flg_reg;
   logic [3:0] bank_reg;
   logic [11:0] index_reg;
   logic [11:0] maddr_reg;
   logic [7:0] mem [0:SBDE_MEM_DEPTH-1];
   logic [7:0] opnd_reg;
   logic [7:0] res_reg;
   sbde_flags_t res_flg_reg;
   logic take_skip_reg;
   logic [11:0] eff_reg;
   sbde_state_t state_reg;
   sbde_state_t state_next;
   sbde_phase_t phase_reg;
   logic [1:0] skip_left_reg;

   // Reset release through two flops
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // Bus address phase decode
   wire accept = i_hsel && i_htrans[1] && i_hready;
   wire hit = (i_haddr[31:8] == 24'h000000) && (i_haddr[1:0] == 2'b00);
   wire busy = (state_reg != SBDE_IDLE);
   wire wr_ok = ap_reg.valid && ap_reg.write;
   wire wr_ctrl = wr_ok && (ap_reg.addr == SBDE_OFF_CTRL);
   wire wr_instr = wr_ok && (ap_reg.addr == SBDE_OFF_INSTR) && !busy;
   wire wr_acc = wr_ok && (ap_reg.addr == SBDE_OFF_ACC) && !busy;
   wire wr_stat = wr_ok && (ap_reg.addr == SBDE_OFF_STATUS) && !busy;
   wire wr_bank = wr_ok && (ap_reg.addr == SBDE_OFF_BANK) && !busy;
   wire wr_index = wr_ok && (ap_reg.addr == SBDE_OFF_INDEX) && !busy;
   wire wr_maddr = wr_ok && (ap_reg.addr == SBDE_OFF_MADDR);
   wire wr_mdata = wr_ok && (ap_reg.addr == SBDE_OFF_MDATA) && !busy;

   // Read selection
   wire [31:0] rd_instr = {13'h0000, last_skip_reg, busy, two_word_reg,
                           instr_reg};
   wire [31:0] rd_mux =
      !hit ? 32'h00000000 :
      (i_haddr[7:0] == SBDE_OFF_CTRL) ? {31'h00000000, ctrl_ext_reg} :
      (i_haddr[7:0] == SBDE_OFF_INSTR) ? rd_instr :
      (i_haddr[7:0] == SBDE_OFF_ACC) ? {24'h000000, acc_reg} :
      (i_haddr[7:0] == SBDE_OFF_STATUS) ? {27'h0000000, flg_reg} :
      (i_haddr[7:0] == SBDE_OFF_BANK) ? {28'h0000000, bank_reg} :
      (i_haddr[7:0] == SBDE_OFF_INDEX) ? {20'h00000, index_reg} :
      (i_haddr[7:0] == SBDE_OFF_MADDR) ? {20'h00000, maddr_reg} :
      (i_haddr[7:0] == SBDE_OFF_MDATA) ? {24'h000000, mem[maddr_reg]} :
      32'h00000000;

   // Bus slave: zero wait states, OKAY always
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ap_reg <= '0;
         o_hrdata <= 32'h00000000;
         o_hreadyout <= 1'b0;
         o_hresp <= 1'b0;
      end
      else
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         if (i_hready)
         begin
            ap_reg.valid <= accept && hit;
            ap_reg.write <= i_hwrite;
            ap_reg.addr <= i_haddr[7:0];
         end
         if (accept && !i_hwrite)
            o_hrdata <= rd_mux;
      end
   end

   // Instruction field decode
   wire is_daw = (instr_reg == SBDE_OPC_DECIMAL_ADJUST);
   wire is_dec = (instr_reg[15:10] == SBDE_OPC_DECREMENT_FILE);
   wire is_cmp = (instr_reg[15:9] == SBDE_OPC_COMPARE_SKIP_LESS);
   wire dest_f = instr_reg[9];
   wire acc_a = instr_reg[8];
   wire [7:0] f_addr = instr_reg[7:0];

   // Effective operand address
   wire ilo = ctrl_ext_reg && (f_addr <= SBDE_ILO_MAX);
   wire [11:0] ilo_addr = index_reg + {4'h0, f_addr};
   wire [3:0] acc_bank = f_addr[7] ? SBDE_ACCESS_HIGH_BANK : 4'h0;
   wire [11:0] eff_addr =
      acc_a ? {bank_reg, f_addr} :
      ilo ? ilo_addr :
      {acc_bank, f_addr};

   // Decrement arithmetic, as add of all ones
   wire [8:0] dec_sum = {1'b0, opnd_reg} + 9'h0ff;
   wire [4:0] dec_lo = {1'b0, opnd_reg[3:0]} + 5'h0f;
   wire [7:0] dec_res = dec_sum[7:0];
   sbde_flags_t dec_flg;
   assign dec_flg.c = dec_sum[8];
   assign dec_flg.dc = dec_lo[4];
   assign dec_flg.z = (dec_res == 8'h00);
   assign dec_flg.n = dec_res[7];
   assign dec_flg.ov = (opnd_reg == 8'h80);

   // Decimal adjust arithmetic
   wire lo_fix = (opnd_reg[3:0] > SBDE_BCD_MAX) || flg_reg.dc;
   wire [3:0] lo_nib = lo_fix ? opnd_reg[3:0] + SBDE_BCD_FIX
                              : opnd_reg[3:0];
   wire [4:0] hi_base = {1'b0, opnd_reg[7:4]} + {4'h0, flg_reg.dc};
   wire hi_fix = (hi_base > {1'b0, SBDE_BCD_MAX}) || flg_reg.c;
   wire [4:0] hi_sum = hi_fix ? hi_base + {1'b0, SBDE_BCD_FIX}
                              : hi_base;
   wire [7:0] daw_res = {hi_sum[3:0], lo_nib};
   sbde_flags_t daw_flg;
   assign daw_flg = '{n: flg_reg.n, ov: flg_reg.ov, z: flg_reg.z,
                      dc: flg_reg.dc, c: hi_sum[4]};

   // Unsigned compare for skip
   wire less = (opnd_reg < acc_reg);

   // Phase and state sequencing
   wire last_q = (phase_reg == SBDE_Q4);
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         SBDE_IDLE:
            if (wr_instr)
               state_next = SBDE_RUN;
         SBDE_RUN:
            if (last_q)
               state_next = take_skip_reg ? SBDE_SKIP : SBDE_IDLE;
         SBDE_SKIP:
            if (last_q && (skip_left_reg == 2'd1))
               state_next = SBDE_IDLE;
         default:
            state_next = SBDE_IDLE;
      endcase
   end

   // Phase counter: Q1..Q4 per instruction cycle
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= SBDE_IDLE;
         phase_reg <= SBDE_Q1;
      end
      else
      begin
         state_reg <= state_next;
         case (phase_reg)
            SBDE_Q1: phase_reg <= busy ? SBDE_Q2 : SBDE_Q1;
            SBDE_Q2: phase_reg <= SBDE_Q3;
            SBDE_Q3: phase_reg <= SBDE_Q4;
            SBDE_Q4: phase_reg <= SBDE_Q1;
            default: phase_reg <= SBDE_Q1;
         endcase
      end
   end

   // Idle cycles left after a skip
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         skip_left_reg <= 2'd0;
      else if (state_reg == SBDE_RUN && last_q)
         skip_left_reg <= two_word_reg ? 2'd2 : 2'd1;
      else if (state_reg == SBDE_SKIP && last_q)
         skip_left_reg <= skip_left_reg - 2'd1;
   end

   // Instruction and control registers
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         instr_reg <= 16'h0000;
         two_word_reg <= 1'b0;
         ctrl_ext_reg <= 1'b0;
         bank_reg <= SBDE_RST_BANK;
         index_reg <= SBDE_RST_INDEX;
         maddr_reg <= 12'h000;
      end
      else
      begin
         if (wr_instr)
         begin
            instr_reg <= i_hwdata[15:0];
            two_word_reg <= i_hwdata[SBDE_INS_TWO_BIT];
         end
         if (wr_ctrl)
            ctrl_ext_reg <= i_hwdata[0];
         if (wr_bank)
            bank_reg <= i_hwdata[3:0];
         if (wr_index)
            index_reg <= i_hwdata[11:0];
         if (wr_maddr)
            maddr_reg <= i_hwdata[11:0];
      end
   end

   // Q2 read, Q3 process
   wire run_q2 = (state_reg == SBDE_RUN) && (phase_reg == SBDE_Q2);
   wire run_q3 = (state_reg == SBDE_RUN) && (phase_reg == SBDE_Q3);
   wire run_q4 = (state_reg == SBDE_RUN) && last_q;
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         opnd_reg <= 8'h00;
         res_reg <= 8'h00;
         res_flg_reg <= '0;
         take_skip_reg <= 1'b0;
         eff_reg <= 12'h000;
      end
      else
      begin
         if (run_q2)
         begin
            opnd_reg <= is_daw ? acc_reg : mem[eff_addr];
            eff_reg <= eff_addr;
         end
         if (run_q3)
         begin
            res_reg <= is_daw ? daw_res : dec_res;
            res_flg_reg <= is_daw ? daw_flg : dec_flg;
            take_skip_reg <= is_cmp && less;
         end
      end
   end

   // Q4 write to accumulator and flags
   wire w_acc = run_q4 && (is_daw || (is_dec && !dest_f));
   wire w_flg = run_q4 && (is_daw || is_dec);
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_reg <= SBDE_RST_ACC;
         flg_reg <= '0;
         last_skip_reg <= 1'b0;
      end
      else
      begin
         if (w_acc)
            acc_reg <= res_reg;
         else if (wr_acc)
            acc_reg <= i_hwdata[7:0];
         if (w_flg)
            flg_reg <= res_flg_reg;
         else if (wr_stat)
            flg_reg <= i_hwdata[4:0];
         if (run_q4)
            last_skip_reg <= take_skip_reg;
      end
   end

   // Data memory: executor writes in Q4, software when idle
   wire w_mem = run_q4 && is_dec && dest_f;
   always_ff @(posedge i_clock)
   begin
      if (w_mem)
         mem[eff_reg] <= res_reg;
      else if (wr_mdata)
         mem[maddr_reg] <= i_hwdata[7:0];
   end

   // Status outputs
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_busy <= 1'b0;
         o_skip_phase <= 1'b0;
      end
      else
      begin
         o_busy <= (state_next != SBDE_IDLE);
         o_skip_phase <= (state_next == SBDE_SKIP);
      end
   end
endmodule : sbde_core
`default_nettype wire

// ==== test/sbde_core_monitor.sv ====
// Concurrent checks on the executor's bus answer and instruction timing.
// Assumes a bind onto sbde_core; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sbde_core_monitor
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_busy,
   input wire logic o_skip_phase
);
   import sbde_pkg::*;
   logic instr_dp_reg;
   logic two_reg;
   // Address phase of an instruction register write
   wire logic instr_ap = i_hsel & i_htrans[1] & i_hready & i_hwrite & (i_haddr == 32'h4);
   // Track the data phase and the two-word flag of the start
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         instr_dp_reg <= 1'b0;
         two_reg <= 1'b0;
      end
      else
      begin
         instr_dp_reg <= instr_ap;
         if (instr_dp_reg & !o_busy)
            two_reg <= i_hwdata[SBDE_INS_TWO_BIT];
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   sequence s_start;
      instr_dp_reg && !o_busy;
   endsequence
   sequence s_run;
      (o_busy && !o_skip_phase) [*4];
   endsequence
   sequence s_skip;
      (o_busy && o_skip_phase) [*4];
   endsequence
   a_run_four: assert property (s_start |=> s_run ##1 (o_skip_phase || !o_busy))
      else $error("execution did not last four cycles");
   a_skip_one: assert property ($rose(o_skip_phase) && !two_reg |-> s_skip ##1 !o_busy)
      else $error("single skip not four idle cycles");
   a_skip_two: assert property ($rose(o_skip_phase) && two_reg
      |-> s_skip ##1 s_skip ##1 !o_busy)
      else $error("two-word skip not eight idle cycles");
   a_skip_busy: assert property (o_skip_phase |-> o_busy)
      else $error("skip phase outside busy");
   a_skip_entry: assert property ($rose(o_skip_phase) |-> $past(o_busy))
      else $error("skip without a compare");
   a_idle_quiet: assert property (!o_busy && !instr_dp_reg |=> !o_busy)
      else $error("busy without a start");
   a_busy_bound: assert property ($rose(o_busy) |-> ##[4:12] !o_busy)
      else $error("busy too long");
   a_ready_held: assert property (o_hreadyout |=> o_hreadyout)
      else $error("wait state inserted");
   a_resp_okay: assert property (o_hresp == 1'b0)
      else $error("error response");
endmodule : sbde_core_monitor
`default_nettype wire

// ==== test/sbde_core_tb.sv ====
// Self-checking bench: drives the executor over its register bus.
// Assumes sbde_core and its monitor are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module sbde_core_tb;
   import sbde_pkg::*;
   logic clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic hready, busy, skip;
   int num_errors = 0, n_compared = 0;
   logic [15:0] opc = {SBDE_OPC_COMPARE_SKIP_LESS, 1'b1, 8'hf1};
   sbde_core i_dut (.i_clock(clock), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
      .o_busy(busy), .o_skip_phase(skip));
   // Clock, 25 ns period
   initial
   begin
      forever #12.5 clock = ~clock;
   end
   // One single AHB transfer, zero or more wait states
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      r = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : wr
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] g;
      ahb(1'b0, a, 32'h0, g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Poll the busy bit until the instruction is done
   task automatic wt();
      logic [31:0] s;
      int k;
      k = 0;
      do
      begin
         ahb(1'b0, SBDE_OFF_INSTR, 32'h0, s);
         k++;
      end
      while (s[SBDE_INS_BUSY_BIT] !== 1'b0 && k < 40);
      // A poll limit that runs out is a hang, counted as a mismatch
      if (s[SBDE_INS_BUSY_BIT] !== 1'b0)
      begin
         num_errors++;
         $display("BAD t=%0t busy=%h exp=%h", $time, s[SBDE_INS_BUSY_BIT], 1'b0);
      end
   endtask : wt
   task automatic mem(input logic [11:0] a, input logic [7:0] v);
      wr(SBDE_OFF_MADDR, {20'h0, a});
      wr(SBDE_OFF_MDATA, {24'h0, v});
   endtask : mem
   task automatic mchk(input logic [11:0] a, input logic [7:0] e);
      wr(SBDE_OFF_MADDR, {20'h0, a});
      chk(SBDE_OFF_MDATA, {24'h0, e});
   endtask : mchk
   // Decrement one memory byte and check both destinations and flags
   task automatic dec(input logic x, input logic a, input logic d, input logic [7:0] f,
      input logic [11:0] ad, input logic [7:0] v, input logic [7:0] r, input logic [4:0] st);
      wr(SBDE_OFF_CTRL, {31'h0, x});
      wr(SBDE_OFF_ACC, 32'h33);
      mem(ad, v);
      wr(SBDE_OFF_INSTR, {16'h0, SBDE_OPC_DECREMENT_FILE, d, a, f});
      wt();
      chk(SBDE_OFF_ACC, {24'h0, d ? 8'h33 : r});
      mchk(ad, d ? r : v);
      chk(SBDE_OFF_STATUS, {27'h0, st});
   endtask : dec
   // Compare against an accumulator of 80, then read the skip bit
   task automatic cmp(input logic [7:0] v, input logic s);
      wr(SBDE_OFF_ACC, 32'h80);
      mem(12'h3f1, v);
      wr(SBDE_OFF_INSTR, {16'h0, opc});
      wt();
      chk(SBDE_OFF_INSTR, {13'h0, s, 2'b00, opc});
   endtask : cmp
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // Watchdog against a hung bus or instruction
   initial
   begin
      #1000000;
      num_errors++;
      results();
   end
   // Decimal adjust inputs and expected results; last case enters with carry set
   logic [7:0] di[4] = '{8'ha5, 8'h09, 8'h66, 8'h12};
   logic [7:0] dq[4] = '{8'h05, 8'h09, 8'h7c, 8'h72};
   logic [4:0] si[4] = '{5'h1c, 5'h00, 5'h02, 5'h01};
   logic [4:0] sq[4] = '{5'h1d, 5'h00, 5'h02, 5'h00};
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      chk(SBDE_OFF_ACC, {24'h0, SBDE_RST_ACC});
      chk(SBDE_OFF_BANK, {28'h0, SBDE_RST_BANK});
      chk(SBDE_OFF_INDEX, {20'h0, SBDE_RST_INDEX});
      wr(8'h20, 32'h5a);
      chk(8'h20, 32'h0);
      // Decimal adjust cases, other flags must survive
      for (int i = 0; i < 4; i++)
      begin
         wr(SBDE_OFF_ACC, {24'h0, di[i]});
         wr(SBDE_OFF_STATUS, {27'h0, si[i]});
         wr(SBDE_OFF_INSTR, {16'h0, SBDE_OPC_DECIMAL_ADJUST});
         wt();
         chk(SBDE_OFF_ACC, {24'h0, dq[i]});
         chk(SBDE_OFF_STATUS, {27'h0, sq[i]});
      end
      wr(SBDE_OFF_BANK, 32'h3);
      wr(SBDE_OFF_INDEX, 32'h200);
      dec(1'b0, 1'b1, 1'b1, 8'h10, 12'h310, 8'h01, 8'h00, 5'h07);
      dec(1'b0, 1'b0, 1'b0, 8'h90, 12'hf90, 8'h80, 8'h7f, 5'h09);
      dec(1'b1, 1'b0, 1'b1, 8'h5f, 12'h25f, 8'h00, 8'hff, 5'h10);
      dec(1'b1, 1'b0, 1'b1, 8'h60, 12'h060, 8'h05, 8'h04, 5'h03);
      wr(SBDE_OFF_CTRL, 32'h0);
      cmp(8'h7f, 1'b1);
      cmp(8'h80, 1'b0);
      cmp(8'hff, 1'b0);
      // Two-word skip with an accumulator write refused while busy
      mem(12'h3f1, 8'h7f);
      wr(SBDE_OFF_INSTR, {15'h0, 1'b1, opc});
      wr(SBDE_OFF_ACC, 32'h11);
      wt();
      chk(SBDE_OFF_ACC, 32'h80);
      chk(SBDE_OFF_INSTR, {13'h0, 3'b101, opc});
      results();
   end
endmodule : sbde_core_tb
bind sbde_core sbde_core_monitor i_mon (.i_clock(i_clock), .i_reset_n(i_reset_n),
   .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
   .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .o_busy(o_busy), .o_skip_phase(o_skip_phase));
`default_nettype wire
